// ==== rtl/branch_bitset_pkg.sv ====
/*
 Constants for the branch and bit-set execution block: opcode patterns,
 field positions, phase encoding and reset values.
 Assumes a four-phase instruction clock built from mclk by the block itself.
*/
package branch_bitset_pkg;
    // Opcode patterns
    localparam logic [4:0] op_bra = 5'h1a;
    localparam logic [7:0] op_branch_if_overflow_clear = 8'he5;
    localparam logic [7:0] op_bnz = 8'he1;
    localparam logic [3:0] op_bsf = 4'h8;
    // Field positions
    localparam int bra_off_msb = 10;
    localparam int bcc_off_msb = 7;
    localparam int bit_idx_lsb = 9;
    localparam int access_bit = 8;
    // Access bank split: low file addresses map to bank 0, high ones to bank 15
    localparam logic [3:0] access_hi_bank = 4'hf;
    localparam logic [7:0] access_split = 8'h80;
    // Reset values
    localparam logic [20:0] pc_reset = 21'h000000;
    localparam logic [15:0] nop_word = 16'h0000;
    // Phases per instruction cycle
    localparam logic [1:0] q1 = 2'h0;
    localparam logic [1:0] q2 = 2'h1;
    localparam logic [1:0] q3 = 2'h2;
    localparam logic [1:0] q4 = 2'h3;
    localparam int pc_step = 2;
endpackage

// ==== rtl/branch_bitset_exec.sv ====
/*
 Execution of the relative branch, the two conditional branches and the
 single-bit set of a file register, one instruction per four mclk phases.
 Assumes the fetch unit presents the prefetched word on instr_word at Q1 and
 fetches from pc_q; data memory answers reads combinationally.
*/
// Overview of operation
// - Decode relative branch from upper bits 11010.
// - Target is incremented PC plus twice offset.
// - Relative branch takes two cycles, flushes prefetch.
// - Decode bit set from nibble 1000 fields.
// - Set chosen bit, keep others and flags.
// - Access bit zero selects fixed access bank.
// - Access bit one uses bank select register.
// - Zero-clear branch jumps only when zero flag 0.
// - Taken conditional two cycles; untaken steps PC by 2.
module branch_bitset_exec
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Instruction stream and flags
    input wire logic [15:0] instr_word,
    input wire logic zero_flag,
    input wire logic overflow_flag,
    input wire logic [3:0] bank_select_register,
    // Data memory
    input wire logic [7:0] mem_rdata,
    output logic [11:0] mem_addr_q,
    output logic [7:0] mem_wdata_q,
    output logic mem_we_q,
    // Program counter and pipeline state
    output logic [20:0] pc_q,
    output logic [1:0] phase_q,
    output logic flush_q
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] ir_q;
    logic is_bra;
    logic is_branch_if_overflow_clear;
    logic is_bnz;
    logic is_bsf;
    logic take;
    logic [20:0] target;
    logic [11:0] file_addr;
    logic [7:0] set_val;
    logic [7:0] held_q;

    // Flushed cycle executes a nop word instead of the prefetch
    always_comb
    begin
        ir_q = flush_q ? branch_bitset_pkg::nop_word : instr_word;
    end

    // Decode runs on the whole word every phase; only phase-gated logic acts on it
    assign is_bra = ir_q[15:11] == branch_bitset_pkg::op_bra;
    assign is_branch_if_overflow_clear = ir_q[15:8] == branch_bitset_pkg::op_branch_if_overflow_clear;
    assign is_bnz = ir_q[15:8] == branch_bitset_pkg::op_bnz;
    assign is_bsf = ir_q[15:12] == branch_bitset_pkg::op_bsf;
    // Flags count only as Q4 ends, so they may settle late in the cycle
    assign take = is_bra || (is_branch_if_overflow_clear && !overflow_flag) || (is_bnz && !zero_flag);

    always_comb
    begin
        // pc_q already points past this word; offsets count words
        if (is_bra)
            target = pc_q + {{9{ir_q[10]}}, ir_q[10:0], 1'b0};
        else
            target = pc_q + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
    end

    // With the access bit clear the bank register is ignored, so common
    // registers stay reachable without reloading it
    always_comb
    begin
        if (!ir_q[branch_bitset_pkg::access_bit])
            file_addr = {(ir_q[7:0] >= branch_bitset_pkg::access_split) ?
                         branch_bitset_pkg::access_hi_bank : 4'h0, ir_q[7:0]};
        else
            file_addr = {bank_select_register, ir_q[7:0]};
    end

    assign set_val = held_q | (8'h01 << ir_q[11:9]);

    ////////////////////////////////////////////////////////////////////////
    // Q1..Q4 counter; reset parks it at Q1 so the first word starts cleanly
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            phase_q <= branch_bitset_pkg::q1;
        else
            phase_q <= phase_q + 2'h1;
    end

    // Program counter: step at Q4, or load target when a branch is taken
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            pc_q <= branch_bitset_pkg::pc_reset;
        else if (phase_q == branch_bitset_pkg::q4)
            pc_q <= take ? target : pc_q + 21'(branch_bitset_pkg::pc_step);
    end

    // The word prefetched under a taken branch is stale; running it as a nop
    // costs one cycle but keeps a single fetch path
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            flush_q <= 1'b0;
        else if (phase_q == branch_bitset_pkg::q4)
            flush_q <= take;
    end

    // Bit set: read in Q2, modify, write back in Q4
    // mem_rdata must be valid for mem_addr_q before Q2 ends
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            mem_addr_q <= 12'h000;
            held_q <= 8'h00;
            mem_wdata_q <= 8'h00;
            mem_we_q <= 1'b0;
        end
        else
        begin
            mem_we_q <= 1'b0;
            if (is_bsf && phase_q == branch_bitset_pkg::q1)
                mem_addr_q <= file_addr;
            if (is_bsf && phase_q == branch_bitset_pkg::q2)
                held_q <= mem_rdata;
            if (is_bsf && phase_q == branch_bitset_pkg::q3)
            begin
                mem_wdata_q <= set_val;
                mem_we_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_branch_target: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q == branch_bitset_pkg::q4 && is_bra) |=> pc_q == $past(target))
        else $error("branch target not loaded");

    sequence flush_cycle;
        flush_q [*4];
    endsequence

    chk_bra_flush: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q == branch_bitset_pkg::q4 && is_bra) |=> flush_cycle)
        else $error("branch did not flush one cycle");

    chk_untaken_step: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q == branch_bitset_pkg::q4 && !take) |=> pc_q == $past(pc_q) + 21'h000002 && !flush_q)
        else $error("untaken branch changed flow");

    chk_bnz_cond: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q == branch_bitset_pkg::q4 && is_bnz && zero_flag) |=> !flush_q)
        else $error("zero-clear branch taken with zero set");

    chk_bsf_write: assert property (@(posedge mclk) disable iff (!rstn)
        mem_we_q |-> phase_q == branch_bitset_pkg::q4)
        else $error("bit set write outside Q4");

    chk_bsf_bits: assert property (@(posedge mclk) disable iff (!rstn)
        mem_we_q |-> (mem_wdata_q & held_q) == held_q && $countones(mem_wdata_q ^ held_q) <= 1)
        else $error("bit set changed other bits");

    chk_bank_sel: assert property (@(posedge mclk) disable iff (!rstn)
        (mem_we_q && ir_q[15:12] == branch_bitset_pkg::op_bsf && ir_q[8]) |->
        mem_addr_q == {bank_select_register, ir_q[7:0]})
        else $error("banked address wrong");

    chk_access_bank: assert property (@(posedge mclk) disable iff (!rstn)
        (mem_we_q && ir_q[15:12] == branch_bitset_pkg::op_bsf && !ir_q[8]) |->
        (mem_addr_q[11:8] == 4'h0 || mem_addr_q[11:8] == 4'hf))
        else $error("access bank address wrong");

    chk_access_split: assert property (@(posedge mclk) disable iff (!rstn)
        (mem_we_q && is_bsf && !ir_q[branch_bitset_pkg::access_bit]) |->
        mem_addr_q == {(ir_q[7:0] < branch_bitset_pkg::access_split) ? 4'h0 : branch_bitset_pkg::access_hi_bank,
        ir_q[7:0]})
        else $error("access bank split wrong");

    chk_bsf_target_bit: assert property (@(posedge mclk) disable iff (!rstn)
        (mem_we_q && is_bsf) |-> mem_wdata_q[ir_q[11:9]])
        else $error("bit set missed its bit");

    // Bit set walk: address after Q1, strobe after Q3, strobe gone after Q4
    sequence bsf_addr_latched;
        mem_addr_q == $past(file_addr) && !mem_we_q;
    endsequence

    sequence bsf_write_pulse;
        mem_we_q ##1 !mem_we_q;
    endsequence

    chk_bsf_steps: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q == branch_bitset_pkg::q1 && is_bsf) |=> bsf_addr_latched ##2 bsf_write_pulse)
        else $error("bit set steps out of order");

    // PC only moves as Q4 ends, so fetch sees one address per cycle
    chk_pc_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q != branch_bitset_pkg::q4) |=> $stable(pc_q))
        else $error("pc moved outside Q4");

    chk_flush_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        flush_q |-> !mem_we_q && !take)
        else $error("flushed cycle did work");

    chk_bra_decode: assert property (@(posedge mclk) disable iff (!rstn)
        (!flush_q && instr_word[15:11] == branch_bitset_pkg::op_bra) |-> take)
        else $error("relative branch not decoded");

    chk_cond_taken: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q == branch_bitset_pkg::q4 && take && !is_bra) |=> flush_q && pc_q == $past(target))
        else $error("taken conditional branch wrong");

    chk_bnz_jump: assert property (@(posedge mclk) disable iff (!rstn)
        (phase_q == branch_bitset_pkg::q4 && is_bnz && !zero_flag) |=> pc_q == $past(target))
        else $error("zero-clear branch not taken");
endmodule

// ==== bench/branch_and_bit_set_execution_test.sv ====
/*
 Self-checking bench for branch_bitset_exec: branches, flushes and bit sets.
 Assumes one instruction per four mclk phases, words issued as Q4 ends.
*/
`define chk(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module branch_and_bit_set_execution_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rstn = 1'b0, zero_flag = 1'b0, overflow_flag = 1'b0, mem_we_q, flush_q, we_s, we_e;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] bank_select_register = 4'h0;
    logic [7:0] mem_rdata = 8'h00, mem_wdata_q, wd_s;
    logic [11:0] mem_addr_q, addr_s;
    logic [20:0] pc_q, pc0, pc_prev;
    logic [1:0] phase_q;
    logic fl0, we_0;
    int n_mismatch = 0, total_checks = 0;
    branch_bitset_exec i_dut (.mclk, .rstn, .instr_word, .zero_flag, .overflow_flag, .bank_select_register,
        .mem_rdata, .mem_addr_q, .mem_wdata_q, .mem_we_q, .pc_q, .phase_q, .flush_q);
    initial forever #20 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Issues one word as Q4 ends and returns in its Q4, so calls run back to back;
    // pc0, fl0 and we_0 hold what the previous word left behind
    task automatic go(input logic [15:0] w, input logic z, v, input logic [3:0] b, input logic [7:0] rd);
        int i = 0;
        while (phase_q !== branch_bitset_pkg::q4 && i < 8)
        begin
            @(posedge mclk);
            #1 i++;
        end
        @(posedge mclk);
        instr_word <= w;
        zero_flag <= z;
        overflow_flag <= v;
        bank_select_register <= b;
        mem_rdata <= rd;
        pc_prev = pc0;
        #1 pc0 = pc_q;
        fl0 = flush_q;
        we_0 = mem_we_q;
        @(posedge mclk);
        #1 addr_s = mem_addr_q;
        we_e = mem_we_q;
        @(posedge mclk);
        #1 we_e |= mem_we_q;
        @(posedge mclk);
        #1 wd_s = mem_wdata_q;
        we_s = mem_we_q;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_bra;
        logic [20:0] e;
        go(16'hd005, 1'b0, 1'b0, 4'h0, 8'h00);
        e = pc0 + 21'h00000a;
        // The bit set lands in the flushed slot and must do nothing
        go(16'h8f12, 1'b0, 1'b0, 4'h3, 8'h0a);
        `chk(pc0, e)
        `chk(fl0, 1'b1)
        `chk(we_s | we_e, 1'b0)
        go(16'hd400, 1'b1, 1'b1, 4'h0, 8'h00);
        `chk(pc0, e + 21'h000002)
        e = pc0 + 21'h1ff800;
        go(16'h0000, 1'b0, 1'b0, 4'h0, 8'h00);
        `chk(pc0, e)
    endtask
    task automatic bsf1(input logic [15:0] w, input logic [3:0] b, input logic [7:0] rd, ed, input logic [11:0] ea);
        go(w, 1'b1, 1'b0, b, rd);
        `chk(addr_s, ea)
        `chk(wd_s, ed)
        `chk({we_s, we_e}, 2'h2)
        go(16'h0000, 1'b0, 1'b0, b, rd);
        `chk({we_0, fl0}, 2'h0)
        `chk(pc0, pc_prev + 21'h000002)
    endtask
    task automatic t_bsf;
        bsf1(16'h8f12, 4'h3, 8'h0a, 8'h8a, 12'h312);
        bsf1(16'h8090, 4'h3, 8'h0a, 8'h0b, 12'hf90);
        bsf1(16'h8612, 4'h5, 8'hff, 8'hff, 12'h012);
    endtask
    // A taken branch flushes the next slot, so a filler word always follows
    task automatic bcc1(input logic [15:0] w, input logic z, v, tk);
        logic [20:0] e;
        go(w, z, v, 4'h0, 8'h00);
        e = tk ? pc0 + {{12{w[7]}}, w[7:0], 1'b0} : pc0 + 21'h000002;
        go(16'h0000, 1'b0, 1'b0, 4'h0, 8'h00);
        `chk(pc0, e)
        `chk(fl0, tk)
    endtask
    task automatic t_bcc;
        bcc1(16'he1f0, 1'b0, 1'b1, 1'b1);
        bcc1(16'he1f0, 1'b1, 1'b0, 1'b0);
        bcc1(16'he510, 1'b1, 1'b0, 1'b1);
        bcc1(16'he510, 1'b0, 1'b1, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge mclk);
        #1 `chk({pc_q, flush_q, mem_we_q, phase_q}, {branch_bitset_pkg::pc_reset, 2'h0, branch_bitset_pkg::q1})
        @(posedge mclk);
        rstn <= 1'b1;
        t_bra;
        t_bsf;
        t_bcc;
        summarize;
    end
    initial
    begin
        #100000 n_mismatch++;
        summarize;
    end
endmodule
